// File: hdl/sdl_slave.v
// Slave end of a serial display link in pixel mode: rebuilds the parallel
// bus, strobe and selects from serial words, and a divided reference clock.
// Assumes all inputs synchronous to CLK_SYS; one serial cycle per
// SER_TICK pulse. Serial words arrive as WORD_VALID with the word bits.
//
// Notes on behaviour
// - The master captures a word on the rising edge of its write strobe.
// - Each word crosses the link in exactly five serial clock cycles.
// - At six-times ratio the data lines idle one serial cycle per word.
// - The rebuilt strobe is low three serial cycles then high the rest.
// - At eight-times ratio the strobe still runs, low 37.5% of period.
// - Sync and data come out with the strobe one serial cycle behind.
// - The reference clock drives only while its disable pin is high.
// - The reference clock runs only while the link is enabled.
// - The reference clock is the serial clock divided by the ratio.
// - The pixel path carries 16 colour bits plus clock and two syncs.
// - The link is held off 4096 cycles, then 40 calibration cycles.
`timescale 1ns/100ps
`default_nettype none
`include "sdl_regs.vh"
module sdl_slave #(
  parameter LOCK_CYCLES = `SDL_LOCK_CYCLES
) (
  input  wire        CLK_SYS,
  input  wire        RESET,
  input  wire        LINK_ENABLE,
  input  wire        SER_TICK,
  input  wire        WORD_VALID,
  input  wire [15:0] WORD_DATA,
  input  wire        WORD_SEL1_N,
  input  wire        WORD_SEL2_N,
  input  wire [2:0]  CLOCK_RATIO_FIELD,
  input  wire        REF_CLOCK_OUT_DISABLE_N,
  output reg  [15:0] DATA_OUT,
  output reg         FIRST_DISPLAY_SELECT_N,
  output reg         SECOND_DISPLAY_SELECT_N,
  output reg         WRITE_STROBE_N,
  output wire        REF_CLOCK_OUT,
  output wire        REF_CLOCK_OE,
  output reg         LINK_READY
);
  // ------------------------------------------------------------------
  // Start-up: lock counter then calibration
  // ------------------------------------------------------------------
  localparam ST_LOCK = 2'b00;
  localparam ST_CAL  = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [12:0] cnt_reg;
  reg  [12:0] cnt_next;
  reg         ready_next;
  wire [12:0] lock_last;
  wire [12:0] cal_last;

  // Terminal counts of the two start-up phases
  assign lock_last = LOCK_CYCLES[12:0] - 13'h0001;
  assign cal_last  = {7'h00, `SDL_CAL_CYCLES} - 13'h0001;

  // Next start-up state; losing the link enable restarts the lock
  // count, since the serial clock has to settle again after a stop
  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ready_next = 1'b0;
    if (!LINK_ENABLE)
    begin
      state_next = ST_LOCK;
      cnt_next   = 13'h0000;
    end
    else
    begin
      case (state_reg)
        ST_LOCK:
        begin
          if (cnt_reg == lock_last)
          begin
            state_next = ST_CAL;
            cnt_next   = 13'h0000;
          end
          else
            cnt_next = cnt_reg + 13'h0001;
        end
        ST_CAL:
        begin
          if (cnt_reg == cal_last)
          begin
            state_next = ST_RUN;
            ready_next = 1'b1;
          end
          else
            cnt_next = cnt_reg + 13'h0001;
        end
        ST_RUN:
          ready_next = 1'b1;
        default:
        begin
          state_next = ST_LOCK;
          cnt_next   = 13'h0000;
        end
      endcase
    end
  end

  // Start-up registers; ready is a flop so no glitch reaches the pin
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      state_reg  <= ST_LOCK;
      cnt_reg    <= 13'h0000;
      LINK_READY <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      LINK_READY <= ready_next;
    end
  end

  // ------------------------------------------------------------------
  // Word output and rebuilt strobe, counted in serial cycles
  // ------------------------------------------------------------------
  reg  [3:0]  ph_reg;      // Serial cycles since word output
  reg  [3:0]  ph_next;
  reg  [3:0]  ph_last;
  reg  [15:0] data_next;
  reg         sel1_next;
  reg         sel2_next;
  reg         stb_next;
  wire        word_take;

  // Last serial cycle of a word slot; only the idle point moves
  // with the ratio, so the low phase stays three serial cycles
  always @*
  begin
    if (CLOCK_RATIO_FIELD == `SDL_RATIO_8X)
      ph_last = `SDL_PH_LAST_8X;
    else
      ph_last = `SDL_WORD_CYCLES;
  end

  // Words are refused silently until start-up has finished
  assign word_take = WORD_VALID & LINK_READY;

  // Data and selects change together; the strobe falls one serial
  // cycle later so the display samples settled data
  always @*
  begin
    data_next = DATA_OUT;
    sel1_next = FIRST_DISPLAY_SELECT_N;
    sel2_next = SECOND_DISPLAY_SELECT_N;
    stb_next  = WRITE_STROBE_N;
    ph_next   = ph_reg;
    if (word_take)
    begin
      data_next = WORD_DATA;
      sel1_next = WORD_SEL1_N;
      sel2_next = WORD_SEL2_N;
    end
    // A dropped link ends any strobe at once rather than leaving
    // the display with half a cycle
    if (!LINK_ENABLE)
    begin
      stb_next = 1'b1;
      ph_next  = `SDL_PH_IDLE;
    end
    else if (word_take)
      ph_next = 4'h0;
    else if (SER_TICK && ph_reg != `SDL_PH_IDLE)
    begin
      if (ph_reg == 4'h0)
        stb_next = 1'b0;
      else if (ph_reg == `SDL_STB_LOW_CYCLES)
        stb_next = 1'b1;
      if (ph_reg == ph_last)
        ph_next = `SDL_PH_IDLE;
      else
        ph_next = ph_reg + 4'h1;
    end
  end

  // Output registers; all data outputs come straight from flops
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      DATA_OUT                <= `SDL_DATA_RST;
      FIRST_DISPLAY_SELECT_N  <= `SDL_SEL_RST;
      SECOND_DISPLAY_SELECT_N <= `SDL_SEL_RST;
      WRITE_STROBE_N          <= `SDL_STB_RST;
      ph_reg                  <= `SDL_PH_IDLE;
    end
    else
    begin
      DATA_OUT                <= data_next;
      FIRST_DISPLAY_SELECT_N  <= sel1_next;
      SECOND_DISPLAY_SELECT_N <= sel2_next;
      WRITE_STROBE_N          <= stb_next;
      ph_reg                  <= ph_next;
    end
  end

  // ------------------------------------------------------------------
  // Reference clock output
  // ------------------------------------------------------------------
  wire ref_raw;

  // Divider restarts whenever the link drops; from four-times ratio up
  // the first high phase after start-up is one serial cycle short
  sdl_clkdiv u_div (
    .clk     (CLK_SYS),
    .rst     (RESET),
    .run     (LINK_ENABLE),
    .tick    (SER_TICK),
    .ratio   (CLOCK_RATIO_FIELD),
    .ref_out (ref_raw)
  );

  // Enable is combinational; a low disable pin keeps the pin off
  assign REF_CLOCK_OE  = REF_CLOCK_OUT_DISABLE_N & LINK_ENABLE;
  assign REF_CLOCK_OUT = ref_raw & REF_CLOCK_OE;
endmodule
`default_nettype wire

// File: hdl/sdl_regs.vh
// Constants for the serial display link pixel-mode block.
// Assumes inclusion by bare name from design files.
`ifndef SDL_REGS_VH
`define SDL_REGS_VH
// Clock rate in kHz and lock / calibration timing
`define SDL_CLK_KHZ        32'h0000_2710
`define SDL_LOCK_CYCLES    13'h1000
`define SDL_CAL_CYCLES     6'h28
// Serial word: 5 serial cycles per word
`define SDL_WORD_CYCLES    4'h5
// Strobe low phase inside a word
`define SDL_STB_LOW_CYCLES 4'h3
// Ratio field codes
`define SDL_RATIO_2X       3'h0
`define SDL_RATIO_4X       3'h1
`define SDL_RATIO_6X       3'h2
`define SDL_RATIO_7X       3'h3
`define SDL_RATIO_8X       3'h4
`define SDL_RATIO_9X       3'h5
`define SDL_RATIO_10X      3'h6
// Word layout: 16 data bits, two selects
`define SDL_WORD_W         18
// Serial-cycle phase code meaning no word in progress
`define SDL_PH_IDLE        4'hF
// Last serial cycle of a word slot at eight-times ratio
`define SDL_PH_LAST_8X     4'h7
// Output reset levels: data cleared, selects and strobe inactive
`define SDL_DATA_RST       16'h0000
`define SDL_SEL_RST        1'b1
`define SDL_STB_RST        1'b1
`endif

// File: hdl/sdl_clkdiv.v
// Reference clock divider: divides the serial cycle enable by a ratio.
// Assumes a single system clock; serial cycles arrive as enable pulses.
`timescale 1ns/100ps
`default_nettype none
`include "sdl_regs.vh"
module sdl_clkdiv (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire       tick,
  input  wire [2:0] ratio,
  output reg        ref_out
);
  reg  [3:0] cnt_reg;
  reg  [3:0] div;
  // Divisor from ratio field; reserved code falls back to 2
  always @*
  begin
    case (ratio)
      `SDL_RATIO_2X:  div = 4'h2;
      `SDL_RATIO_4X:  div = 4'h4;
      `SDL_RATIO_6X:  div = 4'h6;
      `SDL_RATIO_7X:  div = 4'h7;
      `SDL_RATIO_8X:  div = 4'h8;
      `SDL_RATIO_9X:  div = 4'h9;
      `SDL_RATIO_10X: div = 4'hA;
      default:        div = 4'h2;
    endcase
  end
  // Counter; high for first half of the divided period, rounded down
  always @(posedge clk)
  begin
    if (rst || !run)
    begin
      cnt_reg <= 4'h0;
      ref_out <= 1'b0;
    end
    else if (tick)
    begin
      cnt_reg <= (cnt_reg + 4'h1 >= div) ? 4'h0 : cnt_reg + 4'h1;
      ref_out <= ((cnt_reg + 4'h1 >= div) ? 4'h0 : cnt_reg + 4'h1)
                 < {1'b0, div[3:1]};
    end
  end
endmodule
`default_nettype wire

// File: dv/sdl_checker.sv
// Port timing checker for sdl_slave.
// Assumes a bind onto sdl_slave; single clock domain.
`timescale 1ns/100ps
`default_nettype none
module sdl_checker (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        LINK_ENABLE,
  input wire logic        SER_TICK,
  input wire logic        WORD_VALID,
  input wire logic [15:0] WORD_DATA,
  input wire logic        REF_CLOCK_OUT_DISABLE_N,
  input wire logic [15:0] DATA_OUT,
  input wire logic        WRITE_STROBE_N,
  input wire logic        REF_CLOCK_OUT,
  input wire logic        REF_CLOCK_OE,
  input wire logic        LINK_READY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Ticks seen in the low phase; a counter avoids long repetitions
  logic [1:0] low_reg;
  always @(posedge CLK_SYS)
    low_reg <= WRITE_STROBE_N ? 2'h0 : low_reg + {1'b0, SER_TICK};
  property p_data;
    WORD_VALID && LINK_READY |=> DATA_OUT == $past(WORD_DATA);
  endproperty
  a_data: assert property (p_data) else $error("word lost");
  property p_hold; !WRITE_STROBE_N && SER_TICK && low_reg < 2'h2
    |=> !WRITE_STROBE_N; endproperty
  a_hold: assert property (p_hold) else $error("strobe short");
  property p_rise; !WRITE_STROBE_N && SER_TICK && low_reg == 2'h2
    |=> WRITE_STROBE_N; endproperty
  a_rise: assert property (p_rise) else $error("strobe long");
  property p_fall; $fell(WRITE_STROBE_N) |-> $past(SER_TICK); endproperty
  a_fall: assert property (p_fall) else $error("strobe off tick");
  property p_off; !LINK_ENABLE |=> !LINK_READY; endproperty
  a_off: assert property (p_off) else $error("ready while off");
  property p_idle; !LINK_READY |-> WRITE_STROBE_N; endproperty
  a_idle: assert property (p_idle) else $error("strobe early");
  property p_oe; !REF_CLOCK_OUT_DISABLE_N |-> !REF_CLOCK_OE; endproperty
  a_oe: assert property (p_oe) else $error("clock driven");
  property p_ref; !LINK_ENABLE [*2] |-> !REF_CLOCK_OUT; endproperty
  a_ref: assert property (p_ref) else $error("clock runs");
endmodule
bind sdl_slave sdl_checker u_chk (
  .CLK_SYS                 (CLK_SYS),
  .RESET                   (RESET),
  .LINK_ENABLE             (LINK_ENABLE),
  .SER_TICK                (SER_TICK),
  .WORD_VALID              (WORD_VALID),
  .WORD_DATA               (WORD_DATA),
  .REF_CLOCK_OUT_DISABLE_N (REF_CLOCK_OUT_DISABLE_N),
  .DATA_OUT                (DATA_OUT),
  .WRITE_STROBE_N          (WRITE_STROBE_N),
  .REF_CLOCK_OUT           (REF_CLOCK_OUT),
  .REF_CLOCK_OE            (REF_CLOCK_OE),
  .LINK_READY              (LINK_READY)
);
`default_nettype wire

// File: dv/sdl_master_model.sv
// Far-side word source feeding sdl_slave: serial ticks and words.
// Assumes one clock; one serial cycle every two clocks.
`timescale 1ns/100ps
`default_nettype none
module sdl_master_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [2:0]  last,
  input  wire logic [17:0] word,
  output var  logic        tick,
  output var  logic        valid,
  output var  logic [17:0] bus
);
  logic [2:0] slot_reg;
  logic       send;
  initial {tick, valid, bus, slot_reg} = 23'h00_0000;
  // A word takes 5 serial cycles, then idle cycles up to the slot end
  assign send = !tick && slot_reg == 3'h0 && go;
  always @(posedge clk)
  begin
    tick <= !tick;
    if (tick)
      slot_reg <= (slot_reg >= last) ? 3'h0 : slot_reg + 3'h1;
    valid <= send;
    bus <= send ? word : ~bus; // Idle lines toggle every clock between the last word and its inverse
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for sdl_slave driven by the word source model.
// Assumes the model and checker files compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b1;
  logic        go = 1'b0;
  logic        dis_n = 1'b1;
  logic [2:0]  ratio = 3'h2;
  logic [2:0]  last = 3'h5;
  logic [17:0] word = 18'h0_0000;
  logic [17:0] bus;
  logic [15:0] dout;
  logic        tick, valid, s1, s2, stb, rclk, roe, rdy;
  int          fails = 0, checks = 0, cyc = 0, rises = 0, n;
  sdl_master_model far (.clk(clk), .go(go), .last(last), .word(word),
                        .tick(tick), .valid(valid), .bus(bus));
  sdl_slave #(.LOCK_CYCLES(16)) dut (.CLK_SYS(clk), .RESET(rst),
    .LINK_ENABLE(en), .SER_TICK(tick), .WORD_VALID(valid),
    .WORD_DATA(bus[15:0]), .WORD_SEL1_N(bus[16]), .WORD_SEL2_N(bus[17]),
    .CLOCK_RATIO_FIELD(ratio), .REF_CLOCK_OUT_DISABLE_N(dis_n),
    .DATA_OUT(dout), .FIRST_DISPLAY_SELECT_N(s1),
    .SECOND_DISPLAY_SELECT_N(s2), .WRITE_STROBE_N(stb),
    .REF_CLOCK_OUT(rclk), .REF_CLOCK_OE(roe), .LINK_READY(rdy));
  // 100 ns clock; the hang guard sits far past the expected run
  initial forever #50 clk = ~clk;
  always @(posedge rclk) rises++;
  always @(posedge clk) if (++cyc == 3000) print_verdict;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic t_ready;
    rst = 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 200) @(negedge clk) n++;
    check(n, 56);
    $display("ready test done");
  endtask
  // Back-to-back pixels at one ratio; two displays flip line sync on
  // the selects, a single display keeps the spare select high
  task automatic t_pix(input logic [2:0] code, input logic [2:0] slot,
                       input int high, input logic one);
    ratio = code;
    last = slot;
    go = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      word = one ? {2'h2, 16'h5A3C + i[15:0]}
                 : {~i[0], i[0], 16'hA5C3 + i[15:0]};
      n = 0;
      while (stb !== 1'b0 && n < 40) @(negedge clk) n++;
      if (i > 0) check(n, high);
      check({s2, s1, dout}, word);
      n = 0;
      while (stb !== 1'b1 && n < 40) @(negedge clk) n++;
      check(n, 6);
    end
    go = 1'b0;
    $display("pixel test done");
  endtask
  task automatic t_ref;
    for (int r = 0; r < 2; r++)
    begin
      ratio = r ? 3'h0 : 3'h2;
      repeat (16) @(negedge clk);
      rises = 0;
      repeat (48) @(negedge clk);
      check(rises, r ? 12 : 4);
      check(roe, 1);
    end
    dis_n = 1'b0;
    @(negedge clk) check(roe, 0);
    en = 1'b0;
    repeat (3) @(negedge clk);
    check({rdy, rclk}, 0);
    $display("clock test done");
  endtask
  task print_verdict;
    fails += (cyc >= 3000);
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    t_ready;
    t_pix(3'h2, 3'h5, 6, 1'b0);
    t_pix(3'h4, 3'h7, 10, 1'b1);
    t_ref;
    print_verdict;
  end
endmodule
`default_nettype wire
